// ### src/period_match_timer_defines.svh
`ifndef PERIOD_MATCH_TIMER_DEFINES_SVH
`define PERIOD_MATCH_TIMER_DEFINES_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CTRL_ADDR 8'h00
`define COUNT_ADDR 8'h04
`define PERIOD_ADDR 8'h08
`define STATUS_ADDR 8'h0c
`define MASK_ADDR 8'h10
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define CTRL_RST 7'h00
`define COUNT_RST 8'h00
`define PERIOD_RST 8'hff
`define CTRL_MSB 6
`define OUTPS_MSB 6
`define OUTPS_LSB 3
`define EN_BIT 2
`define CKPS_MSB 1
`define CKPS_LSB 0
`define DATA_MSB 7
// ----------------------------------------
// timing counts
// ----------------------------------------
`define INST_DIV_LAST 2'h3
`define PRE_LAST_1 4'h0
`define PRE_LAST_4 4'h3
`define PRE_LAST_16 4'hf
`define SCALE_ZERO 4'h0
`define SCALE_ONE 4'h1
`define COUNT_ONE 8'h01
`endif

// ### src/timer_pkg.sv
package timer_pkg;
	typedef enum logic [1:0] {
		in_div_1 = 2'b00,
		in_div_4 = 2'b01,
		in_div_16 = 2'b10,
		in_div_16_alt = 2'b11
	} in_div_e;
	typedef enum logic [2:0] {
		sel_ctrl = 3'b000,
		sel_count = 3'b001,
		sel_period = 3'b010,
		sel_status = 3'b011,
		sel_mask = 3'b100,
		sel_none = 3'b111
	} reg_sel_e;
	typedef struct packed {
		logic [3:0] match_divider_select;
		logic count_enable;
		in_div_e input_divider_select;
	} ctrl_s;
	typedef struct packed {
		logic [3:0] cnt;
	} scale_state_s;
endpackage

// ### src/input_prescaler.sv
`timescale 1ns/1ps
`include "period_match_timer_defines.svh"
module input_prescaler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick_in,
	input wire logic clear,
	input wire timer_pkg::in_div_e sel,
	output logic tick_out
);
	timer_pkg::scale_state_s st_reg;
	timer_pkg::scale_state_s st_next;
	logic [3:0] last;
	always_comb begin
		unique case (sel)
			timer_pkg::in_div_1: last = `PRE_LAST_1;
			timer_pkg::in_div_4: last = `PRE_LAST_4;
			timer_pkg::in_div_16: last = `PRE_LAST_16;
			timer_pkg::in_div_16_alt: last = `PRE_LAST_16;
		endcase
		tick_out = tick_in && !clear && (st_reg.cnt >= last);
		st_next = st_reg;
		if (clear) begin
			st_next.cnt = `SCALE_ZERO;
		end else if (tick_in) begin
			// >= guards a ratio lowered while the count sits above it
			st_next.cnt = (st_reg.cnt >= last) ? `SCALE_ZERO : st_reg.cnt + `SCALE_ONE;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // input_prescaler

// ### src/match_postscaler.sv
`timescale 1ns/1ps
`include "period_match_timer_defines.svh"
module match_postscaler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic match_evt,
	input wire logic clear,
	input wire logic [3:0] sel,
	output logic done
);
	timer_pkg::scale_state_s st_reg;
	timer_pkg::scale_state_s st_next;
	always_comb begin
		done = match_evt && !clear && (st_reg.cnt >= sel);
		st_next = st_reg;
		if (clear) begin
			st_next.cnt = `SCALE_ZERO;
		end else if (match_evt) begin
			st_next.cnt = (st_reg.cnt >= sel) ? `SCALE_ZERO : st_reg.cnt + `SCALE_ONE;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // match_postscaler

// ### src/period_match_timer.sv
// What this block does
// - readable, writable 8-bit count and period registers
// - count increments from zero per prescaled instruction tick
// - prescale codes divide by 1, 4, 16
// - compare count with period, flag equality
// - match restarts count at zero next step
// - match events feed 1 to 16 postscaler
// - postscaler completion raises interrupt request
// - enable bit 2 runs or stops timer
// - reset clears count, period becomes FFh
// - count, control writes and reset clear scalers
// - control write keeps count value unchanged
// - match event offered as serial shift clock
// - control bit 7 ignores writes, reads zero
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "period_match_timer_defines.svh"
module period_match_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic timer_match,
	output logic shift_clk_tick
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		timer_pkg::ctrl_s ctrl;
		logic [7:0] count;
		logic [7:0] period;
		logic irq_flag;
		logic irq_mask;
		logic [1:0] inst_div;
		logic [31:0] rdata;
		logic err;
		logic rd_cap;
		logic match;
		logic shift_clk;
		logic irq_out;
	} timer_state_s;

	timer_state_s st_reg;
	timer_state_s st_next;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic timer_pkg::reg_sel_e decode(input logic [7:0] addr);
		timer_pkg::reg_sel_e sel;
		unique case (addr)
			`CTRL_ADDR: sel = timer_pkg::sel_ctrl;
			`COUNT_ADDR: sel = timer_pkg::sel_count;
			`PERIOD_ADDR: sel = timer_pkg::sel_period;
			`STATUS_ADDR: sel = timer_pkg::sel_status;
			`MASK_ADDR: sel = timer_pkg::sel_mask;
			default: sel = timer_pkg::sel_none;
		endcase
		return sel;
	endfunction

	timer_pkg::reg_sel_e addr_sel;
	logic setup_phase;
	logic access_done;
	logic wr_ctrl;
	logic wr_count;
	logic wr_period;
	logic wr_mask;
	logic rd_status;

	assign addr_sel = decode(paddr);
	assign setup_phase = psel && !penable;
	// no wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign access_done = psel && penable && pready;
	assign wr_ctrl = access_done && pwrite && (addr_sel == timer_pkg::sel_ctrl);
	assign wr_count = access_done && pwrite && (addr_sel == timer_pkg::sel_count);
	assign wr_period = access_done && pwrite && (addr_sel == timer_pkg::sel_period);
	assign wr_mask = access_done && pwrite && (addr_sel == timer_pkg::sel_mask);
	assign rd_status = access_done && !pwrite && (addr_sel == timer_pkg::sel_status);

	// ----------------------------------------
	// scalers
	// ----------------------------------------
	logic inst_tick;
	logic run_tick;
	logic pre_tick;
	logic scaler_clear;
	logic at_period;
	logic match_evt;
	logic post_done;

	// pclk stands for the oscillator; the instruction clock is a quarter of it
	assign inst_tick = (st_reg.inst_div == `INST_DIV_LAST);
	assign run_tick = inst_tick && st_reg.ctrl.count_enable;
	assign scaler_clear = wr_count || wr_ctrl;
	assign at_period = (st_reg.count == st_reg.period);

	input_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(run_tick),
		.clear(scaler_clear),
		.sel(st_reg.ctrl.input_divider_select),
		.tick_out(pre_tick)
	);

	// a stopped timer produces no match event
	assign match_evt = pre_tick && at_period;

	match_postscaler u_postscaler (
		.pclk(pclk),
		.presetn(presetn),
		.match_evt(match_evt),
		.clear(scaler_clear),
		.sel(st_reg.ctrl.match_divider_select),
		.done(post_done)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.inst_div = st_reg.inst_div + 2'h1;

		// count register: software write wins over counting
		if (wr_count) begin
			st_next.count = pwdata[`DATA_MSB:0];
		end else if (pre_tick) begin
			if (at_period) begin
				st_next.count = `COUNT_RST;
			end else begin
				st_next.count = st_reg.count + `COUNT_ONE;
			end
		end

		// control write touches only the fields, never the count
		if (wr_ctrl) begin
			st_next.ctrl = timer_pkg::ctrl_s'(pwdata[`CTRL_MSB:0]);
		end

		if (wr_period) begin
			st_next.period = pwdata[`DATA_MSB:0];
		end

		if (wr_mask) begin
			st_next.irq_mask = pwdata[0];
		end

		// sticky flag: read clears only what was returned, a new set wins
		st_next.irq_flag = (st_reg.irq_flag && !(rd_status && st_reg.rd_cap)) || post_done;

		// read data and error are registered during the setup cycle
		if (setup_phase) begin
			st_next.err = (addr_sel == timer_pkg::sel_none);
			st_next.rd_cap = st_reg.irq_flag;
			st_next.rdata = 32'h0000_0000;
			if (!pwrite) begin
				unique case (addr_sel)
					timer_pkg::sel_ctrl: st_next.rdata = {25'h0, st_reg.ctrl};
					timer_pkg::sel_count: st_next.rdata = {24'h0, st_reg.count};
					timer_pkg::sel_period: st_next.rdata = {24'h0, st_reg.period};
					timer_pkg::sel_status: st_next.rdata = {31'h0, st_reg.irq_flag};
					timer_pkg::sel_mask: st_next.rdata = {31'h0, st_reg.irq_mask};
					timer_pkg::sel_none: st_next.rdata = 32'h0000_0000;
				endcase
			end
		end else if (access_done) begin
			st_next.err = 1'b0;
			st_next.rdata = 32'h0000_0000;
		end

		// outputs follow the state the registers will hold
		st_next.match = st_next.ctrl.count_enable && (st_next.count == st_next.period);
		st_next.shift_clk = match_evt;
		st_next.irq_out = st_next.irq_flag && st_next.irq_mask;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.ctrl <= timer_pkg::ctrl_s'(`CTRL_RST);
			st_reg.count <= `COUNT_RST;
			st_reg.period <= `PERIOD_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = st_reg.rdata;
	assign pslverr = st_reg.err && access_done;
	assign irq = st_reg.irq_out;
	assign timer_match = st_reg.match;
	assign shift_clk_tick = st_reg.shift_clk;
endmodule // period_match_timer

// ### bench/period_match_timer_sva.sv
`timescale 1ns/1ps
`include "period_match_timer_defines.svh"
module period_match_timer_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic timer_match,
	input wire logic shift_clk_tick
);
	// ------
	// enable as software last wrote it
	// ------
	logic en_q;
	logic acc;
	assign acc = psel && penable;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0;
		end else if (acc && pwrite && paddr == `CTRL_ADDR) begin
			en_q <= pwdata[`EN_BIT];
		end
	end
	// ------
	// properties
	// ------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	err_window_a: assert property (pslverr |-> acc) else $error("slverr outside access");
	unmapped_a: assert property (acc && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |-> pslverr
		&& prdata == 32'h0) else $error("unmapped access");
	ctrl_msb_a: assert property (acc && !pwrite && paddr == `CTRL_ADDR |-> !prdata[7])
		else $error("control bit7 set");
	tick_pulse_a: assert property (shift_clk_tick |=> !shift_clk_tick)
		else $error("tick too long");
	tick_cause_a: assert property (shift_clk_tick |-> timer_match || $past(timer_match) ||
		$past(timer_match, 2)) else $error("tick without match");
	irq_sticky_a: assert property ($fell(irq) |-> $past(psel) || $past(psel, 2))
		else $error("irq fell alone");
	irq_cause_a: assert property ($rose(irq) |-> shift_clk_tick || $past(shift_clk_tick) ||
		$past(psel) || $past(psel, 2)) else $error("irq without event");
	stop_quiet_a: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) |->
		!timer_match && !shift_clk_tick) else $error("stopped timer active");
	irq_seen_c: cover property ($rose(irq));
	err_seen_c: cover property (pslverr);
	tick_seen_c: cover property (shift_clk_tick && timer_match);
endmodule // period_match_timer_sva
bind period_match_timer period_match_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .timer_match(timer_match), .shift_clk_tick(shift_clk_tick));

// ### bench/tb.sv
`timescale 1ns/1ps
`include "period_match_timer_defines.svh"
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, v;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, timer_match, shift_clk_tick, er;
	logic [3:0] m;
	int failures = 0, check_count = 0, c, n;
	period_match_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.timer_match(timer_match), .shift_clk_tick(shift_clk_tick));
	always #2.5 pclk = ~pclk;
	// ------
	// tasks
	// ------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			failures++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		check(rd, exp);
	endtask
	// cycles until the next shift tick, bounded
	task automatic wait_tick();
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (shift_clk_tick !== 1'b1 && c < 2000);
		if (shift_clk_tick !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask
	// shift ticks seen up to and including the one that raises irq, bounded
	task automatic ticks_to_irq();
		n = 0;
		c = 0;
		while (irq !== 1'b1 && c < 500) begin
			@(posedge pclk);
			c++;
			n += (shift_clk_tick === 1'b1);
		end
		if (irq !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask
	function automatic int dv(input int s);
		return (s == 0) ? 1 : (s == 1) ? 4 : 16;
	endfunction
	// ------
	// sequence
	// ------
	initial begin
		void'($urandom(32'he371cac4));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`CTRL_ADDR, 32'h0);
		rchk(`COUNT_ADDR, 32'h0);
		rchk(`PERIOD_ADDR, 32'hff);
		rchk(`STATUS_ADDR, 32'h0);
		rchk(8'h14, 32'h0);
		check({31'h0, er}, 32'h1);
		v = 8'($urandom);
		apb(1'b1, `PERIOD_ADDR, v);
		rchk(`PERIOD_ADDR, {24'h0, v});
		v = 8'($urandom);
		apb(1'b1, `COUNT_ADDR, v);
		apb(1'b1, `CTRL_ADDR, 8'hfb);
		rchk(`CTRL_ADDR, 32'h7b);
		repeat (40) @(posedge pclk);
		rchk(`COUNT_ADDR, {24'h0, v});
		check({31'h0, timer_match}, 32'h0);
		for (int s = 0; s < 4; s++) begin
			v = 8'($urandom_range(7));
			apb(1'b1, `PERIOD_ADDR, v);
			apb(1'b1, `COUNT_ADDR, 8'h00);
			apb(1'b1, `CTRL_ADDR, 8'h04 | 8'(s));
			wait_tick();
			wait_tick();
			check(32'(c), 32'(4 * dv(s) * (v + 1)));
			check({31'h0, timer_match}, {31'h0, v == 8'h00});
		end
		apb(1'b1, `MASK_ADDR, 8'h01);
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
			apb(1'b1, `CTRL_ADDR, 8'h00);
			apb(1'b1, `PERIOD_ADDR, 8'h00);
			apb(1'b1, `COUNT_ADDR, 8'h00);
			apb(1'b0, `STATUS_ADDR, 8'h00);
			apb(1'b1, `CTRL_ADDR, {1'b0, m, 3'b100});
			ticks_to_irq();
			check(32'(n), 32'(m + 1));
		end
		rchk(`MASK_ADDR, 32'h1);
		// a count write must restart a half-done postscaler (1:4 here)
		apb(1'b1, `CTRL_ADDR, 8'h00);
		apb(1'b0, `STATUS_ADDR, 8'h00);
		apb(1'b1, `CTRL_ADDR, 8'h1c);
		wait_tick();
		apb(1'b1, `COUNT_ADDR, 8'h00);
		ticks_to_irq();
		check(32'(n), 32'h4);
		// stopped first, so only stickiness can keep the flag up
		apb(1'b1, `CTRL_ADDR, 8'h00);
		repeat (30) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		rchk(`STATUS_ADDR, 32'h1);
		rchk(`STATUS_ADDR, 32'h0);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, `MASK_ADDR, 8'h00);
		apb(1'b1, `CTRL_ADDR, 8'h04);
		repeat (30) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, `MASK_ADDR, 8'h01);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		print_verdict();
	end
endmodule // tb
